// *** core/acq_pkg.sv ***
// Shared constants, enumerations and carriers of the acquisition sequencer
package acq_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_RUN = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h04;
	localparam logic [7:0] REG_TRIG = 8'h08;
	localparam logic [7:0] REG_LEVEL = 8'h0c;
	localparam logic [7:0] REG_WAIT = 8'h10;
	localparam logic [7:0] REG_WIN = 8'h14;
	localparam logic [7:0] REG_CMD = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1c;
	// Field positions
	localparam int CFG_ADV_BIT = 0;
	localparam int CFG_SAF_BIT = 1;
	localparam int CFG_CORR_BIT = 2;
	localparam int CFG_START_LSB = 4;
	localparam int CFG_COUNT_LSB = 12;
	localparam int TRIG_NORMAL_BIT = 0;
	localparam int TRIG_FALL_BIT = 1;
	localparam int TRIG_SRC_LSB = 2;
	localparam int TRIG_AC_BIT = 4;
	localparam int TRIG_EXTARM_BIT = 5;
	localparam int TRIG_PCT_BIT = 6;
	localparam int CMD_MAN_BIT = 0;
	localparam int CMD_BUS_BIT = 1;
	localparam int CMD_MAP_BIT = 2;
	localparam int STAT_MAP_BIT = 2;
	localparam int STAT_SLOT_LSB = 4;
	localparam int STAT_FILL_LSB = 12;
	localparam int STAT_PHASE_LSB = 20;
	// Reset values and limits
	localparam logic [4:0] SLOT_MIN = 5'h01;
	localparam logic [4:0] SLOT_MAX = 5'h10;
	localparam logic [4:0] RST_COUNT = 5'h01;
	localparam logic [4:0] RST_START = 5'h01;
	localparam logic [15:0] RST_WIN = 16'h0064;
	localparam logic [10:0] WAIT_MAX = 11'h500;
	localparam logic [3:0] MAP_SERIES = 4'h8;
	// Timing
	localparam int AUTO_TIMEOUT_MS = 360;
	localparam int CLK_HZ = 100_000_000;
	localparam int AUTO_TIMEOUT_CYC = AUTO_TIMEOUT_MS * (CLK_HZ / 1000);

	typedef enum logic [1:0] {RUN_STOPPED, RUN_CONT, RUN_SAF} run_state_e;
	typedef enum logic [1:0] {PH_IDLE, PH_ARMED, PH_DELAY, PH_STORE} phase_e;
	typedef enum logic [1:0] {SRC_CHA, SRC_CHB, SRC_SUM, SRC_EXT} trig_src_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;

	typedef struct packed {
		logic pct;
		logic ext_arm;
		logic ac;
		trig_src_e src;
		logic falling;
		logic normal;
	} trig_cfg_s;

	typedef struct packed {
		run_state_e run;
		phase_e phase;
		logic adv;
		logic saf;
		logic corr;
		logic [4:0] start;
		logic [4:0] count;
		trig_cfg_s tcfg;
		logic [15:0] level;
		logic [10:0] wait_frac;
		logic [15:0] win;
		logic map_run;
		logic [3:0] map_cnt;
		logic [3:0] slot;
		logic [4:0] filled;
		logic [25:0] tmo;
		logic [18:0] dly;
		logic [15:0] wcnt;
		logic prev_src;
		logic trig;
		logic store;
		logic [31:0] rdata;
	} seq_state_s;
endpackage

// *** core/acq_trigger_sequencer.sv ***
// Acquisition and trigger sequencer of the waveform recorder
//
// Contract
// - Record count in advance mode is 1 to 16, default 1.
// - After slot 16 is filled, slot 1 is written next.
// - After wrapping, keep filling until filled count equals record count.
// - With stop-after-fill on, acquisition stops after the last required slot.
// - With stop-after-fill, triggers after completion are ignored until restart.
// - Without stop-after-fill, acquire repeatedly until stopped.
// - Report stop-after-fill running, then stopped; the setting stays on.
// - Run state commandable as stopped, continuous or stop-after-fill; readable.
// - Correction enable passes through to waveform processing.
// - Mapping run performs a series of acquisitions; status resets to stopped.
// - Auto mode fires its own trigger 360 ms after sequence start.
// - Normal mode triggers on event, manual button or bus command only.
// - Edge select rising or falling; channel inversion does not change it.
// - Threshold held signed, in volts or percent of full scale.
// - Channel inversion leaves the threshold setting untouched.
// - Source is channel A, channel B, sum or external.
// - Coupling AC or DC internally; external source forces AC.
// - Programmable wait after trigger, up to five windows, before storing.
// - Wait held as a fraction of the window, survives window changes.
// - With external arming, no trigger unless arm input is low.
// - Arm input ignored under internal arming or auto mode.
// - Start slot 1 to 16; only slot in single mode, first in advance.
module acq_trigger_sequencer #(
	parameter int unsigned AUTO_TIMEOUT = acq_pkg::AUTO_TIMEOUT_CYC
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire acq_pkg::bus_req_s bus,
	output logic [31:0] rdata,
	input wire logic [3:0] src_above,
	input wire logic ext_arm_n,
	input wire logic man_trig,
	output logic trig_o,
	output logic store_o,
	output logic [3:0] slot_o,
	output acq_pkg::trig_src_e source_o,
	output logic falling_o,
	output logic coupling_ac_o,
	output logic [15:0] threshold_o,
	output logic threshold_pct_o,
	output logic correct_en_o,
	output logic map_run_o
);
	import acq_pkg::*;

	localparam logic [25:0] TMO_LAST = 26'(AUTO_TIMEOUT - 1);

	seq_state_s s_r;
	seq_state_s s_nxt;
	logic sel_lvl;
	logic ev;
	logic cmd_wr;
	logic bus_trig;
	logic arm_ok;
	logic timeout;
	logic fire;
	logic store_end;
	logic last_slot;
	logic [4:0] required;
	logic [26:0] dprod;
	logic [18:0] dcyc;

	// Clamp a slot number or count into 1..16
	function automatic logic [4:0] clamp_slot(input logic [4:0] v);
		logic [4:0] r;
		r = v;
		if (v < SLOT_MIN) begin
			r = SLOT_MIN;
		end else if (v > SLOT_MAX) begin
			r = SLOT_MAX;
		end
		return r;
	endfunction

	// Trigger qualification from selected comparator and commands
	always_comb begin
		sel_lvl = src_above[s_r.tcfg.src];
		ev = s_r.tcfg.falling ? (~sel_lvl & s_r.prev_src) : (sel_lvl & ~s_r.prev_src);
		cmd_wr = bus.wr && (bus.addr == REG_CMD);
		bus_trig = cmd_wr && (bus.wdata[CMD_MAN_BIT] || bus.wdata[CMD_BUS_BIT]);
		arm_ok = !s_r.tcfg.ext_arm || !s_r.tcfg.normal || !ext_arm_n;
		timeout = !s_r.tcfg.normal && (s_r.tmo == TMO_LAST);
		fire = timeout || (arm_ok && (ev || man_trig || bus_trig));
		required = s_r.adv ? s_r.count : SLOT_MIN;
		store_end = (s_r.phase == PH_STORE) && (s_r.wcnt == s_r.win - 16'h0001);
		last_slot = (s_r.filled + 5'h01) == required;
		dprod = 27'(s_r.wait_frac) * 27'(s_r.win);
		dcyc = dprod[26:8];
	end

	// Next-state logic
	always_comb begin
		s_nxt = s_r;
		s_nxt.trig = 1'b0;
		s_nxt.rdata = 32'h0000_0000;
		s_nxt.prev_src = sel_lvl;
		case (s_r.phase)
			PH_IDLE: begin
				s_nxt.store = 1'b0;
			end
			PH_ARMED: begin
				s_nxt.tmo = (s_r.tmo == TMO_LAST) ? s_r.tmo : s_r.tmo + 26'h1;
				if (fire) begin
					s_nxt.trig = 1'b1;
					s_nxt.tmo = 26'h0;
					s_nxt.dly = dcyc;
					s_nxt.wcnt = 16'h0;
					if (dcyc == 19'h0) begin
						s_nxt.phase = PH_STORE;
						s_nxt.store = 1'b1;
					end else begin
						s_nxt.phase = PH_DELAY;
					end
				end
			end
			PH_DELAY: begin
				s_nxt.dly = s_r.dly - 19'h1;
				if (s_r.dly == 19'h1) begin
					s_nxt.phase = PH_STORE;
					s_nxt.store = 1'b1;
				end
			end
			PH_STORE: begin
				s_nxt.wcnt = s_r.wcnt + 16'h1;
				if (store_end) begin
					s_nxt.store = 1'b0;
					s_nxt.tmo = 26'h0;
					s_nxt.phase = PH_ARMED;
					s_nxt.filled = s_r.filled + 5'h01;
					if (s_r.adv) begin
						s_nxt.slot = s_r.slot + 4'h1;
					end
					if (s_r.map_run) begin
						s_nxt.map_cnt = s_r.map_cnt + 4'h1;
					end
					if (last_slot) begin
						s_nxt.filled = 5'h00;
						s_nxt.slot = 4'(s_r.start - 5'h01);
						if (s_r.run == RUN_SAF) begin
							s_nxt.run = RUN_STOPPED;
							s_nxt.phase = PH_IDLE;
						end
					end
					if (s_r.map_run && s_r.map_cnt == MAP_SERIES - 4'h1) begin
						s_nxt.map_run = 1'b0;
						s_nxt.run = RUN_STOPPED;
						s_nxt.phase = PH_IDLE;
					end
				end
			end
			default: begin
				s_nxt.phase = PH_IDLE;
			end
		endcase
		// Register writes take precedence over the sequence
		if (bus.wr) begin
			case (bus.addr)
				REG_RUN: begin
					s_nxt.store = 1'b0;
					s_nxt.filled = 5'h00;
					s_nxt.tmo = 26'h0;
					s_nxt.slot = 4'(s_r.start - 5'h01);
					s_nxt.phase = PH_ARMED;
					case (bus.wdata[1:0])
						2'h1: s_nxt.run = s_r.saf ? RUN_SAF : RUN_CONT;
						2'h2: begin
							s_nxt.run = RUN_SAF;
							s_nxt.saf = 1'b1;
						end
						default: begin
							s_nxt.run = RUN_STOPPED;
							s_nxt.phase = PH_IDLE;
						end
					endcase
				end
				REG_CFG: begin
					s_nxt.adv = bus.wdata[CFG_ADV_BIT];
					s_nxt.saf = bus.wdata[CFG_SAF_BIT];
					s_nxt.corr = bus.wdata[CFG_CORR_BIT];
					s_nxt.start = clamp_slot(bus.wdata[CFG_START_LSB +: 5]);
					s_nxt.count = clamp_slot(bus.wdata[CFG_COUNT_LSB +: 5]);
					if (s_r.run != RUN_STOPPED) begin
						s_nxt.run = bus.wdata[CFG_SAF_BIT] ? RUN_SAF : RUN_CONT;
					end
				end
				REG_TRIG: begin
					s_nxt.tcfg.normal = bus.wdata[TRIG_NORMAL_BIT];
					s_nxt.tcfg.falling = bus.wdata[TRIG_FALL_BIT];
					s_nxt.tcfg.src = trig_src_e'(bus.wdata[TRIG_SRC_LSB +: 2]);
					s_nxt.tcfg.ext_arm = bus.wdata[TRIG_EXTARM_BIT];
					s_nxt.tcfg.ac = bus.wdata[TRIG_AC_BIT];
					s_nxt.tcfg.pct = bus.wdata[TRIG_PCT_BIT];
					if (trig_src_e'(bus.wdata[TRIG_SRC_LSB +: 2]) == SRC_EXT) begin
						s_nxt.tcfg.ac = 1'b1;
						s_nxt.tcfg.pct = 1'b0;
					end
				end
				REG_LEVEL: s_nxt.level = bus.wdata[15:0];
				REG_WAIT: begin
					s_nxt.wait_frac = (bus.wdata[15:0] > 16'(WAIT_MAX)) ? WAIT_MAX
						: bus.wdata[10:0];
				end
				REG_WIN: begin
					s_nxt.win = (bus.wdata[15:0] == 16'h0) ? 16'h1 : bus.wdata[15:0];
				end
				REG_CMD: begin
					if (bus.wdata[CMD_MAP_BIT]) begin
						s_nxt.map_run = 1'b1;
						s_nxt.map_cnt = 4'h0;
						// Also restarts a run that the sequence stops in this cycle
						if (s_nxt.run == RUN_STOPPED) begin
							s_nxt.run = RUN_CONT;
							s_nxt.phase = PH_ARMED;
							s_nxt.tmo = 26'h0;
							s_nxt.filled = 5'h00;
							s_nxt.slot = 4'(s_r.start - 5'h01);
						end
					end
				end
				default: begin
				end
			endcase
		end
		// Read data, registered for the following cycle
		if (bus.rd) begin
			case (bus.addr)
				REG_RUN: s_nxt.rdata = {30'h0, s_r.run};
				REG_CFG: begin
					s_nxt.rdata = {15'h0, s_r.count, 3'h0, s_r.start, 1'b0,
						s_r.corr, s_r.saf, s_r.adv};
				end
				REG_TRIG: s_nxt.rdata = {25'h0, s_r.tcfg};
				REG_LEVEL: s_nxt.rdata = {16'h0, s_r.level};
				REG_WAIT: s_nxt.rdata = {21'h0, s_r.wait_frac};
				REG_WIN: s_nxt.rdata = {16'h0, s_r.win};
				REG_STATUS: begin
					s_nxt.rdata = {10'h0, s_r.phase, 3'h0, s_r.filled, 3'h0,
						5'(s_r.slot) + 5'h01, 1'b0, s_r.map_run, s_r.run};
				end
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_r <= '0;
			s_r.run <= RUN_STOPPED;
			s_r.phase <= PH_IDLE;
			s_r.start <= RST_START;
			s_r.count <= RST_COUNT;
			s_r.win <= RST_WIN;
			s_r.tcfg.src <= SRC_CHA;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign rdata = s_r.rdata;
	assign trig_o = s_r.trig;
	assign store_o = s_r.store;
	assign slot_o = s_r.slot;
	assign source_o = s_r.tcfg.src;
	assign falling_o = s_r.tcfg.falling;
	assign coupling_ac_o = s_r.tcfg.ac;
	assign threshold_o = s_r.level;
	assign threshold_pct_o = s_r.tcfg.pct;
	assign correct_en_o = s_r.corr;
	assign map_run_o = s_r.map_run;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence seq_fill_done;
		store_end && last_slot && s_r.run == RUN_SAF && !bus.wr;
	endsequence

	sequence seq_wrap;
		store_end && !last_slot && s_r.adv && s_r.slot == 4'hf && !bus.wr;
	endsequence

	sequence seq_map_start;
		bus.wr && bus.addr == REG_CMD && bus.wdata[CMD_MAP_BIT];
	endsequence

	a_slot_wrap: assert property (seq_wrap |=> s_r.slot == 4'h0 && store_o == 1'b0)
		else $error("slot did not wrap to the first slot");
	a_fill_stops: assert property (seq_fill_done |=> s_r.run == RUN_STOPPED ##0 s_r.saf)
		else $error("run did not stop after last slot");
	a_idle_no_trig: assert property (s_r.phase == PH_IDLE && !bus.wr |=> !trig_o[*2])
		else $error("trigger while stopped");
	a_auto_timeout: assert property (s_r.phase == PH_ARMED && timeout && !bus.wr |=> trig_o)
		else $error("auto trigger missing at timeout");
	a_normal_cause: assert property (trig_o && $past(s_r.tcfg.normal)
		|-> $past(ev || man_trig || bus_trig))
		else $error("normal mode trigger without cause");
	a_ext_arm_gate: assert property (trig_o && $past(s_r.tcfg.normal) && $past(s_r.tcfg.ext_arm)
		|-> !$past(ext_arm_n))
		else $error("trigger while external arm high");
	a_ext_coupling: assert property (source_o == SRC_EXT |-> coupling_ac_o && !threshold_pct_o)
		else $error("external source not AC coupled");
	a_slot_ranges: assert property (s_r.count inside {[1:16]} && s_r.start inside {[1:16]})
		else $error("record count or start slot out of range");
	a_map_start: assert property (seq_map_start |=> map_run_o && s_r.run != RUN_STOPPED)
		else $error("mapping run did not start");
	a_timeout_clear: assert property (trig_o && $past(s_r.phase) == PH_ARMED |-> s_r.tmo == 26'h0)
		else $error("timeout counter not cleared on trigger");
endmodule

// *** sim/host_ctrl.sv ***
// Host controller model driving the register bus of the sequencer
module host_ctrl (
	input wire logic sys_clk,
	output acq_pkg::bus_req_s bus
);
	timeunit 1ns;
	timeprecision 1ps;
	import acq_pkg::*;

	// Bus idle at time zero
	initial bus = '0;

	// One-cycle write; entered just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
	endtask

	// One-cycle read; data is picked up by the bench monitor
	task automatic rd(input logic [7:0] a);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
	endtask

	// Strobes low; address and data toggle so stale values never look valid
	task automatic idle(input int n);
		repeat (n) begin
			bus <= '{addr: ~bus.addr, wdata: ~bus.wdata, wr: 1'b0, rd: 1'b0};
			@(posedge sys_clk);
		end
	endtask
endmodule

// *** sim/testbench.sv ***
// Self-checking bench of the acquisition trigger sequencer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import acq_pkg::*;
	localparam int TMO = 20;
	logic sys_clk, reset, ext_arm_n, man_trig;
	logic rd_d = 1'b0;
	logic [3:0] src_above, slot_o;
	logic [31:0] rdata, exp_q[$];
	bus_req_s bus;
	trig_src_e source_o;
	logic trig_o, store_o, falling_o, coupling_ac_o, threshold_pct_o, correct_en_o, map_run_o;
	logic [15:0] threshold_o;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [7:0] def_a[6] = '{REG_RUN, REG_CFG, REG_TRIG, REG_WAIT, REG_WIN, 8'h20};
	logic [31:0] def_e[6] = '{32'h0, 32'h1010, 32'h0, 32'h0, 32'h64, 32'h0};

	acq_trigger_sequencer #(.AUTO_TIMEOUT(TMO)) dut (.sys_clk(sys_clk), .reset(reset),
		.bus(bus), .rdata(rdata), .src_above(src_above), .ext_arm_n(ext_arm_n),
		.man_trig(man_trig), .trig_o(trig_o), .store_o(store_o), .slot_o(slot_o),
		.source_o(source_o), .falling_o(falling_o), .coupling_ac_o(coupling_ac_o),
		.threshold_o(threshold_o), .threshold_pct_o(threshold_pct_o),
		.correct_en_o(correct_en_o), .map_run_o(map_run_o));
	host_ctrl host (.sys_clk(sys_clk), .bus(bus));

	// Clock of 10 ns
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic end_of_test();
		if (errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cmp_out(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// Note the expected word, then issue the read
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		host.rd(a);
	endtask

	// Edges until a trigger pulse is seen; lim means none
	task automatic wait_trig(input int lim, output int n);
		for (n = 0; n < lim; n++) begin
			host.idle(1);
			if (trig_o === 1'b1)
				return;
		end
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge sys_clk) begin
		rd_d <= bus.rd;
		if (rd_d === 1'b1)
			cmp_out("rdata", exp_q.pop_front(), rdata);
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_of_test();
		end
	end

	// Main sequence
	initial begin
		int n;
		int k;
		int c;
		logic [31:0] v;
		logic f;
		void'($urandom(48615));
		reset = 1'b1;
		ext_arm_n = 1'b1;
		man_trig = 1'b0;
		src_above = 4'h0;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		cmp_out("map_run", 32'h0, 32'(map_run_o));
		for (int i = 0; i < 6; i++)
			chk_rd(def_a[i], def_e[i]);
		// Every source, random edge, external overrides
		for (int s = 0; s < 4; s++) begin
			f = 1'($urandom);
			src_above <= 4'($urandom);
			host.wr(REG_TRIG, 32'h40 | 32'(s << 2) | (32'(f) << 1));
			host.idle(1);
			cmp_out("source", 32'(s), 32'(source_o));
			cmp_out("edge", 32'(f), 32'(falling_o));
			cmp_out("coupling", 32'(s == 3), 32'(coupling_ac_o));
			cmp_out("units", 32'(s != 3), 32'(threshold_pct_o));
			v = (s == 3) ? 32'h1c : 32'h40 | 32'(s << 2);
			chk_rd(REG_TRIG, v | (32'(f) << 1));
		end
		v = $urandom;
		host.wr(REG_LEVEL, v);
		host.idle(1);
		cmp_out("threshold", {16'h0, v[15:0]}, 32'(threshold_o));
		chk_rd(REG_LEVEL, {16'h0, v[15:0]});
		host.wr(REG_CFG, 32'h1014);
		host.idle(1);
		cmp_out("correct", 32'h1, 32'(correct_en_o));
		host.wr(REG_CFG, 32'h1010);
		host.idle(1);
		cmp_out("correct", 32'h0, 32'(correct_en_o));
		// Auto trigger fires with arm input blocked
		src_above <= {3'($urandom), 1'b0};
		host.wr(REG_WIN, 32'h2);
		host.wr(REG_TRIG, 32'h20);
		host.wr(REG_RUN, 32'h1);
		wait_trig(TMO + 10, n);
		cmp_out("auto", 32'h1, 32'(n >= TMO - 3 && n <= TMO + 3));
		// External arming gates a manual request
		host.wr(REG_TRIG, 32'h21);
		host.wr(REG_RUN, 32'h1);
		man_trig <= 1'b1;
		host.idle(1);
		man_trig <= 1'b0;
		wait_trig(10, n);
		cmp_out("arm_block", 32'd10, 32'(n));
		ext_arm_n <= 1'b0;
		src_above[0] <= 1'b1;
		wait_trig(10, n);
		cmp_out("arm_pass", 32'h1, 32'(n < 10));
		// Random internal channel and edge; other comparators must not fire
		host.wr(REG_RUN, 32'h0);
		c = $urandom_range(2);
		f = 1'($urandom);
		src_above <= {4{f}};
		host.wr(REG_TRIG, 32'h1 | (32'(c) << 2) | (32'(f) << 1));
		host.wr(REG_RUN, 32'h1);
		v = $urandom;
		v[c] = f;
		src_above <= v[3:0];
		wait_trig(4, n);
		cmp_out("other_src", 32'd4, 32'(n));
		src_above[c] <= ~f;
		wait_trig(4, n);
		cmp_out("edge_trig", 32'd1, 32'(n));
		host.wr(REG_RUN, 32'h0);
		// Delay of one window before storing
		host.wr(REG_WIN, 32'h4);
		host.wr(REG_WAIT, 32'h100);
		host.wr(REG_TRIG, 32'h01);
		host.wr(REG_RUN, 32'h1);
		host.wr(REG_CMD, 32'h2);
		wait_trig(10, n);
		cmp_out("bus_trig", 32'h0, 32'(n));
		for (k = 0; k < 20 && store_o !== 1'b1; k++)
			host.idle(1);
		cmp_out("delay", 32'd4, 32'(k));
		host.idle(8);
		chk_rd(REG_RUN, 32'h1);
		host.wr(REG_WIN, 32'h8);
		chk_rd(REG_WAIT, 32'h100);
		// Advance from slot 15 with wrap, then stop after fill
		host.wr(REG_WAIT, 32'h0);
		host.wr(REG_CFG, 32'h30f3);
		host.wr(REG_RUN, 32'h2);
		for (int i = 0; i < 3; i++) begin
			host.wr(REG_CMD, 32'h2);
			wait_trig(10, n);
			cmp_out("slot", 32'((14 + i) % 16), 32'(slot_o));
			host.idle(12);
			if (i == 0)
				chk_rd(REG_RUN, 32'h2);
		end
		chk_rd(REG_RUN, 32'h0);
		chk_rd(REG_CFG, 32'h30f3);
		host.wr(REG_CMD, 32'h2);
		wait_trig(10, n);
		cmp_out("ignored", 32'd10, 32'(n));
		host.wr(REG_CMD, 32'h4);
		host.idle(1);
		cmp_out("map_run", 32'h1, 32'(map_run_o));
		// Reset in mid-run restores the defaults
		reset <= 1'b1;
		host.idle(2);
		reset <= 1'b0;
		cmp_out("map_run", 32'h0, 32'(map_run_o));
		chk_rd(REG_CFG, 32'h1010);
		chk_rd(REG_STATUS, 32'h10);
		host.idle(2);
		end_of_test();
	end
endmodule
